//--- design/hds_supervisor.sv
// hub drive status supervisor: lamps, jog keys, presence test, required-drive bookkeeping
//
// What this block does
// - per network port: both lamps dark unlinked, green idle, yellow flickers 10 Hz on data
// - bus-fault lamp off in exchange, 2 Hz flash when connected, steady when unconnected
// - status-fault lamp off normally, 2 Hz for 3 s on identify, steady on faults
// - switch 0 shows collective status, above zero shows the selected drive only
// - collective lamp alternates red and green at 5 Hz during presence test
// - collective: red on required comm error, red plus green on required drive error
// - collective: extra drives flash green 2 Hz, or red plus green if one errs
// - collective: steady green only when exactly required drives present, none erring
// - single drive: off absent unrequired, red comm error, red+green drive error, else green
// - network run commands pass only while the drive-select switch reads 0
// - backward key jogs via set 163-165, forward via 160-162, default 1/16 turn
// - power-up presence test finds drives, restores baud, timeout, assigns address 1
// - presence test reloads the saved required-port record from non-volatile store
// - after test: red if required missing, green if exact, 2 Hz green if extra
// - nothing required at delivery; runs refused until required via parameter 151+(n-1)*100
// - writing -4 to parameter 29 reruns the whole presence test
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "hds_map.svh"

module hds_supervisor #(
  parameter int unsigned FLICKER_HALF = `HDS_CLK_HZ / (2 * `HDS_FLICKER_HZ),
  parameter int unsigned ALT_HALF     = `HDS_CLK_HZ / (2 * `HDS_ALT_HZ),
  parameter int unsigned FLASH_HALF   = `HDS_CLK_HZ / (2 * `HDS_FLASH_HZ),
  parameter int unsigned IDENT_CYC    = `HDS_IDENT_S * `HDS_CLK_HZ
) (
  input  wire  logic                   clk_i,
  input  wire  logic                   rst_i,
  input  wire  logic                   ce_i,
  // classic wishbone slave
  input  wire  logic                   wb_cyc_i,
  input  wire  logic                   wb_stb_i,
  input  wire  logic                   wb_we_i,
  input  wire  logic [7:0]             wb_adr_i,
  input  wire  logic [3:0]             wb_sel_i,
  input  wire  logic [31:0]            wb_dat_i,
  output logic       [31:0]            wb_dat_o,
  output logic                         wb_ack_o,
  output logic                         irq_o,
  // network side status
  input  wire  logic [1:0]             link_up_i,
  input  wire  logic [1:0]             activity_i,
  input  wire  logic                   net_connected_i,
  input  wire  logic                   cyclic_exchange_i,
  input  wire  logic                   identify_req_i,
  input  wire  logic                   watchdog_timeout_i,
  input  wire  logic                   system_fault_i,
  input  wire  logic                   diag_pending_i,
  // parameter writes arriving from the controller
  input  wire  logic                   param_wr_i,
  input  wire  logic [15:0]            param_num_i,
  input  wire  logic [31:0]            param_val_i,
  // network run commands, one per drive
  input  wire  logic [7:0]             run_cmd_i,
  output logic       [7:0]             run_en_o,
  // operator elements
  input  wire  logic [3:0]             drive_select_switch_i,
  input  wire  logic                   backward_jog_key_i,
  input  wire  logic                   forward_jog_key_i,
  output logic                         jog_start_o,
  output logic       [2:0]             jog_drive_o,
  output logic       [15:0]            jog_param_base_o,
  // drive health from the rs485 engine
  input  wire  logic [7:0]             comm_err_i,
  input  wire  logic [7:0]             drive_err_i,
  // presence test handshakes
  input  wire  logic [7:0]             nv_required_i,
  output logic       [7:0]             required_o,
  output logic                         probe_req_o,
  output logic       [2:0]             probe_port_o,
  input  wire  logic                   probe_done_i,
  input  wire  logic                   probe_found_i,
  output logic                         cfg_req_o,
  output logic       [3:0]             cfg_baud_o,
  output logic       [15:0]            cfg_timeout_o,
  output logic       [7:0]             cfg_addr_o,
  input  wire  logic                   cfg_ack_i,
  output logic                         testing_o,
  // lamps
  output hds_pkg::hds_port_lamp_t [1:0] port_lamp_o,
  output logic                         bus_fault_lamp_o,
  output logic                         status_fault_lamp_o,
  output hds_pkg::hds_rg_t             rs485_lamp_o
);

  hds_pkg::hds_state_t state;
  logic [2:0]  port;
  logic [7:0]  required;
  logic [7:0]  present;
  logic [31:0] baud;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_en;
  logic [31:0] ident_cnt;
  logic [2:0]  phase;          // 0: 10 Hz, 1: 5 Hz, 2: 2 Hz
  logic        bwd_q;
  logic        fwd_q;
  logic        fault_q;
  logic        rerun;
  logic [7:0]  req_hit;
  logic [31:0] wmask;
  logic        wb_req;
  logic        wb_wr;
  logic [7:0]  miss;
  logic [7:0]  derr;
  logic [7:0]  extra;
  logic        any_fault;
  logic [7:0]  refused;
  logic [3:0]  irq_set;
  logic [3:0]  clr_mask;
  logic [2:0]  sel_idx;
  logic        sel_valid;
  hds_pkg::hds_rg_t next_rs485;

  localparam int unsigned HALF [3] = '{FLICKER_HALF, ALT_HALF, FLASH_HALF};

  // blink phases from one prescaler per rate; reset clears them so lamps start in step
  for (genvar r = 0; r < 3; r++) begin : g_blink
    logic [31:0] cnt;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt      <= 32'h0000_0000;
        phase[r] <= 1'b0;
      end else if (ce_i) begin
        if (cnt == 32'(HALF[r] - 1)) begin
          cnt      <= 32'h0000_0000;
          phase[r] <= ~phase[r];
        end else begin
          cnt <= cnt + 32'h0000_0001;
        end
      end
    end
  end

  // parameter numbers that mark drive n as required
  for (genvar n = 0; n < 8; n++) begin : g_req
    localparam logic [15:0] PNUM = 16'(`HDS_PARAM_REQ_BASE + 16'(n) * `HDS_PARAM_REQ_STEP);
    assign req_hit[n] = param_wr_i && (param_num_i == PNUM);
  end

  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr   = wb_req && wb_we_i;
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // rerun request from the controller parameter or from the ctrl register bit 0
  assign rerun = (param_wr_i && param_num_i == `HDS_PARAM_PRESENCE &&
                  param_val_i == `HDS_PRESENCE_CMD) ||
                 (wb_wr && wb_adr_i[7:2] == `HDS_OFS_CTRL >> 2 && wb_sel_i[0] && wb_dat_i[0]);

  // presence test sequencer; reset is power-up so the test begins at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= hds_pkg::ST_LOAD;
      port  <= 3'h0;
    end else if (ce_i) begin
      case (state)
        hds_pkg::ST_IDLE: begin
          if (rerun) begin
            state <= hds_pkg::ST_LOAD;
          end
        end
        hds_pkg::ST_LOAD: begin
          port  <= 3'h0;
          state <= hds_pkg::ST_PROBE;
        end
        hds_pkg::ST_PROBE: begin
          if (probe_done_i) begin
            state <= probe_found_i ? hds_pkg::ST_CFG : hds_pkg::ST_NEXT;
          end
        end
        hds_pkg::ST_CFG: begin
          if (cfg_ack_i) begin
            state <= hds_pkg::ST_NEXT;
          end
        end
        hds_pkg::ST_NEXT: begin
          if (port == 3'h7) begin
            state <= hds_pkg::ST_IDLE;
          end else begin
            port  <= port + 3'h1;
            state <= hds_pkg::ST_PROBE;
          end
        end
        default: state <= hds_pkg::ST_IDLE;
      endcase
    end
  end

  // presence map is rebuilt by every test; absent ports read as absent until probed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      present <= 8'h00;
    end else if (ce_i) begin
      if (state == hds_pkg::ST_LOAD) begin
        present <= 8'h00;
      end else if (state == hds_pkg::ST_PROBE && probe_done_i) begin
        present[port] <= probe_found_i;
      end
    end
  end

  // required map: nothing after reset, reload from store at test start, then marks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      required <= `HDS_RST_REQUIRED;
    end else if (ce_i) begin
      if (state == hds_pkg::ST_LOAD) begin
        required <= nv_required_i;
      end else if (|req_hit) begin
        for (int i = 0; i < 8; i++) begin
          if (req_hit[i]) begin
            required[i] <= (param_val_i == `HDS_REQ_MARK);
          end
        end
      end else if (wb_wr && wb_adr_i[7:2] == `HDS_OFS_REQUIRED >> 2 && wb_sel_i[0]) begin
        required <= wb_dat_i[7:0];
      end
    end
  end

  // stored baud codes, four bits per port, kept by software across power cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud <= `HDS_RST_BAUD;
    end else if (ce_i && wb_wr && wb_adr_i[7:2] == `HDS_OFS_BAUD >> 2) begin
      baud <= (baud & ~wmask) | (wb_dat_i & wmask);
    end
  end

  // probe and config requests held until the rs485 engine answers
  assign probe_req_o   = (state == hds_pkg::ST_PROBE);
  assign probe_port_o  = port;
  assign cfg_req_o     = (state == hds_pkg::ST_CFG);
  assign cfg_addr_o    = `HDS_RS485_ADDR;
  assign testing_o     = (state != hds_pkg::ST_IDLE);
  assign required_o    = required;

  // restore this port's baud and scale the message-complete time with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_baud_o    <= 4'h0;
      cfg_timeout_o <= `HDS_MCT_BASE;
    end else if (ce_i) begin
      cfg_baud_o    <= baud[{port, 2'b00} +: 4];
      cfg_timeout_o <= `HDS_MCT_BASE >> baud[{port, 2'b00} +: 4];
    end
  end

  // run commands pass only for required drives and only with the switch at 0
  assign refused = run_cmd_i & ~(required & {8{drive_select_switch_i == 4'h0}});
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_en_o <= 8'h00;
    end else if (ce_i) begin
      run_en_o <= run_cmd_i & ~refused;
    end
  end

  // jog keys act on the rising edge; switch 0 selects no drive, so keys are ignored there
  assign sel_idx   = 3'(drive_select_switch_i - 4'h1);
  assign sel_valid = (drive_select_switch_i != 4'h0) && (drive_select_switch_i <= 4'h8);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bwd_q            <= 1'b0;
      fwd_q            <= 1'b0;
      jog_start_o      <= 1'b0;
      jog_drive_o      <= 3'h0;
      jog_param_base_o <= `HDS_JOG_FWD_BASE;
    end else if (ce_i) begin
      bwd_q       <= backward_jog_key_i;
      fwd_q       <= forward_jog_key_i;
      jog_start_o <= 1'b0;
      // backward wins if both keys land together; step size lives in the drive set
      if (sel_valid && backward_jog_key_i && !bwd_q) begin
        jog_start_o      <= 1'b1;
        jog_drive_o      <= sel_idx;
        jog_param_base_o <= `HDS_JOG_BWD_BASE;
      end else if (sel_valid && forward_jog_key_i && !fwd_q) begin
        jog_start_o      <= 1'b1;
        jog_drive_o      <= sel_idx;
        jog_param_base_o <= `HDS_JOG_FWD_BASE;
      end
    end
  end

  // identify window counts down from the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ident_cnt <= 32'h0000_0000;
    end else if (ce_i) begin
      if (identify_req_i) begin
        ident_cnt <= 32'(IDENT_CYC);
      end else if (ident_cnt != 32'h0000_0000) begin
        ident_cnt <= ident_cnt - 32'h0000_0001;
      end
    end
  end

  // network side lamps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_lamp_o         <= '0;
      bus_fault_lamp_o    <= 1'b1;
      status_fault_lamp_o <= 1'b0;
    end else if (ce_i) begin
      for (int p = 0; p < 2; p++) begin
        port_lamp_o[p].link     <= link_up_i[p];
        port_lamp_o[p].activity <= link_up_i[p] & activity_i[p] & phase[0];
      end
      if (cyclic_exchange_i) begin
        bus_fault_lamp_o <= 1'b0;
      end else if (net_connected_i) begin
        bus_fault_lamp_o <= phase[2];
      end else begin
        bus_fault_lamp_o <= 1'b1;
      end
      // a standing fault outranks the identify flash
      if (watchdog_timeout_i || system_fault_i || diag_pending_i) begin
        status_fault_lamp_o <= 1'b1;
      end else begin
        status_fault_lamp_o <= (ident_cnt != 32'h0000_0000) & phase[2];
      end
    end
  end

  // drive health classes; a missing required drive counts as a comm error
  assign miss      = required & (comm_err_i | ~present);
  assign derr      = required & ~miss & drive_err_i;
  assign extra     = present & ~required;
  assign any_fault = !testing_o && (|miss);

  // rs485 lamp selection
  always_comb begin
    next_rs485 = '0;
    if (drive_select_switch_i != 4'h0) begin
      if (!sel_valid || (!present[sel_idx] && !required[sel_idx])) begin
        next_rs485 = '0;
      end else if (miss[sel_idx] || comm_err_i[sel_idx]) begin
        next_rs485.red = 1'b1;
      end else if (drive_err_i[sel_idx]) begin
        next_rs485 = '{red: 1'b1, green: 1'b1};
      end else begin
        next_rs485.green = 1'b1;
      end
    end else if (testing_o) begin
      next_rs485 = '{red: phase[1], green: ~phase[1]};
    end else if (|miss) begin
      next_rs485.red = 1'b1;
    end else if (|derr) begin
      next_rs485 = '{red: 1'b1, green: 1'b1};
    end else if (|extra) begin
      next_rs485.green = phase[2];
      next_rs485.red   = phase[2] & (|(extra & drive_err_i));
    end else begin
      next_rs485.green = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rs485_lamp_o <= '0;
    end else if (ce_i) begin
      rs485_lamp_o <= next_rs485;
    end
  end

  // interrupt events; a set in the same cycle as its clear wins
  assign irq_set[`HDS_IRQ_DONE]  = (state == hds_pkg::ST_NEXT) && (port == 3'h7);
  assign irq_set[`HDS_IRQ_IDENT] = identify_req_i;
  assign irq_set[`HDS_IRQ_FAULT] = any_fault && !fault_q;
  assign irq_set[`HDS_IRQ_BLOCK] = |refused;
  assign clr_mask = (wb_wr && wb_adr_i[7:2] == `HDS_OFS_IRQ_CLR >> 2 && wb_sel_i[0]) ?
                    wb_dat_i[3:0] : 4'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 4'h0;
      fault_q  <= 1'b0;
      irq_en   <= `HDS_RST_IRQ_EN;
    end else if (ce_i) begin
      fault_q  <= any_fault;
      irq_stat <= (irq_stat & ~clr_mask) | irq_set;
      if (wb_wr && wb_adr_i[7:2] == `HDS_OFS_IRQ_EN >> 2 && wb_sel_i[0]) begin
        irq_en <= wb_dat_i[3:0];
      end
    end
  end

  assign irq_o = |(irq_stat & irq_en);

  // bus answer one cycle after the strobe; unmapped reads return zero, writes drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i[7:2])
          `HDS_OFS_STATUS >> 2:
            wb_dat_o <= {12'h000, drive_select_switch_i, present, 1'b0, state, 3'h0, testing_o};
          `HDS_OFS_REQUIRED >> 2: wb_dat_o <= {24'h00_0000, required};
          `HDS_OFS_BAUD >> 2:     wb_dat_o <= baud;
          `HDS_OFS_IRQ_STAT >> 2: wb_dat_o <= {28'h000_0000, irq_stat};
          `HDS_OFS_IRQ_EN >> 2:   wb_dat_o <= {28'h000_0000, irq_en};
          `HDS_OFS_LAMPS >> 2:
            wb_dat_o <= {24'h00_0000, port_lamp_o, bus_fault_lamp_o, status_fault_lamp_o,
                         rs485_lamp_o};
          default:                wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : hds_supervisor

//--- design/hds_map.svh
// offsets, field positions, reset values and timing figures of the hub status supervisor
`ifndef HDS_MAP_SVH
`define HDS_MAP_SVH
`define HDS_OFS_CTRL       8'h00
`define HDS_OFS_STATUS     8'h04
`define HDS_OFS_REQUIRED   8'h08
`define HDS_OFS_BAUD       8'h0c
`define HDS_OFS_IRQ_STAT   8'h10
`define HDS_OFS_IRQ_CLR    8'h14
`define HDS_OFS_IRQ_EN     8'h18
`define HDS_OFS_LAMPS      8'h1c
`define HDS_RST_REQUIRED   8'h00
`define HDS_RST_BAUD       32'h0000_0000
`define HDS_RST_IRQ_EN     4'h0
`define HDS_IRQ_DONE       0
`define HDS_IRQ_IDENT      1
`define HDS_IRQ_FAULT      2
`define HDS_IRQ_BLOCK      3
`define HDS_CLK_HZ         10000000
`define HDS_FLICKER_HZ     10
`define HDS_ALT_HZ         5
`define HDS_FLASH_HZ       2
`define HDS_IDENT_S        3
`define HDS_PARAM_REQ_BASE 16'h0097
`define HDS_PARAM_REQ_STEP 16'h0064
`define HDS_PARAM_PRESENCE 16'h001d
`define HDS_PRESENCE_CMD   32'hffff_fffc
`define HDS_REQ_MARK       32'h0000_0001
`define HDS_JOG_FWD_BASE   16'h00a0
`define HDS_JOG_BWD_BASE   16'h00a3
`define HDS_RS485_ADDR     8'h01
`define HDS_MCT_BASE       16'h0800
`endif

//--- design/hds_pkg.sv
// types shared by the hub status supervisor
package hds_pkg;
  typedef struct packed {
    logic red;
    logic green;
  } hds_rg_t;
  typedef struct packed {
    logic link;
    logic activity;
  } hds_port_lamp_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_PROBE = 3'b010,
    ST_CFG   = 3'b011,
    ST_NEXT  = 3'b100
  } hds_state_t;
endpackage : hds_pkg

//--- verification/hds_sup_monitor.sv
// port-level assertions for the hub status supervisor
`timescale 1ns/1ps
module hds_sup_monitor (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         ce_i,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_ack_o,
  input wire logic [1:0]                   link_up_i,
  input wire logic [1:0]                   activity_i,
  input wire logic                         net_connected_i,
  input wire logic                         cyclic_exchange_i,
  input wire logic                         watchdog_timeout_i,
  input wire logic [7:0]                   run_cmd_i,
  input wire logic [7:0]                   run_en_o,
  input wire logic [7:0]                   required_o,
  input wire logic [3:0]                   drive_select_switch_i,
  input wire logic                         backward_jog_key_i,
  input wire logic                         jog_start_o,
  input wire logic [2:0]                   jog_drive_o,
  input wire logic [15:0]                  jog_param_base_o,
  input wire logic                         cfg_req_o,
  input wire logic [3:0]                   cfg_baud_o,
  input wire logic [15:0]                  cfg_timeout_o,
  input wire logic [7:0]                   cfg_addr_o,
  input wire logic                         testing_o,
  input wire hds_pkg::hds_port_lamp_t [1:0] port_lamp_o,
  input wire logic                         bus_fault_lamp_o,
  input wire logic                         status_fault_lamp_o,
  input wire hds_pkg::hds_rg_t             rs485_lamp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus handshake: one-cycle answer, never held
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held high");
  // run enable and lamps lag their inputs by one cycle
  AST_RUN_GATE: assert property (!$past(rst_i) && $past(ce_i) |->
    run_en_o == ($past(run_cmd_i) & $past(required_o) & {8{$past(drive_select_switch_i) == 4'h0}}))
    else $error("run enable mismatch");
  AST_PORT_DARK: assert property (!$past(rst_i) && !$past(link_up_i[0]) |->
    port_lamp_o[0] == 2'b00) else $error("unlinked port lamp lit");
  AST_PORT_IDLE: assert property ($past(link_up_i[1] && !activity_i[1]) && !$past(rst_i) |->
    port_lamp_o[1] == 2'b10) else $error("idle port lamps wrong");
  AST_BF_OFF: assert property ($past(cyclic_exchange_i && net_connected_i) |->
    !bus_fault_lamp_o) else $error("bus fault lamp lit in exchange");
  AST_BF_ON: assert property ($past(!net_connected_i && !cyclic_exchange_i) |->
    bus_fault_lamp_o) else $error("bus fault lamp dark when unconnected");
  AST_SF_ON: assert property ($past(watchdog_timeout_i) && !$past(rst_i) |->
    status_fault_lamp_o) else $error("status fault lamp dark on watchdog");
  AST_SEL_OFF: assert property ($past(drive_select_switch_i) > 4'h8 && !$past(rst_i) |->
    rs485_lamp_o == 2'b00) else $error("lamp lit for no drive");
  AST_TEST_ALT: assert property ($past(testing_o && drive_select_switch_i == 4'h0)
    && !$past(rst_i) |-> rs485_lamp_o.red != rs485_lamp_o.green)
    else $error("lamp not alternating during test");
  AST_JOG_BWD: assert property ($rose(backward_jog_key_i) &&
    drive_select_switch_i inside {[4'h1:4'h8]} |=> jog_start_o && jog_param_base_o == 16'h00a3
    && jog_drive_o == $past(drive_select_switch_i[2:0]) - 3'h1) else $error("backward jog wrong");
  AST_CFG_VAL: assert property (cfg_req_o |-> cfg_addr_o == 8'h01 &&
    cfg_timeout_o == (16'h0800 >> cfg_baud_o)) else $error("drive config values wrong");
endmodule : hds_sup_monitor

bind hds_supervisor hds_sup_monitor mon_u (.*);

//--- verification/hds_drive_model.sv
// behavioural rs485 drive bank answering presence probes and config writes
`timescale 1ns/1ps
module hds_drive_model #(
  parameter logic [7:0] PRESENT = 8'h05
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       probe_req_i,
  input  wire logic [2:0] probe_port_i,
  input  wire logic       cfg_req_i,
  output logic            probe_done_o,
  output logic            probe_found_o,
  output logic            cfg_ack_o
);
  logic [2:0] wait_cnt;
  // reply delay grows with port number
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_cnt <= 3'h0;
      probe_done_o <= 1'b0;
      cfg_ack_o <= 1'b0;
      probe_found_o <= 1'b0;
    end else begin
      probe_done_o <= 1'b0;
      cfg_ack_o <= 1'b0;
      probe_found_o <= ~probe_found_o;  // meaningless outside done, so it keeps moving
      if ((probe_req_i || cfg_req_i) && !probe_done_o && !cfg_ack_o) begin
        wait_cnt <= wait_cnt + 3'h1;
        if (wait_cnt == probe_port_i) begin
          wait_cnt <= 3'h0;
          probe_done_o <= probe_req_i;
          probe_found_o <= PRESENT[probe_port_i];
          cfg_ack_o <= cfg_req_i && !probe_req_i;
        end
      end
    end
  end
endmodule : hds_drive_model

//--- verification/testbench.sv
// self-checking bench for the hub status supervisor
`timescale 1ns/1ps
module testbench;
  localparam int FH = 20;  // brief flash half period
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, pwr = 1'b0;
  logic conn = 1'b0, exch = 1'b0, ident = 1'b0, wdt = 1'b0, bkey = 1'b0, fkey = 1'b0;
  logic preq, pdone, pfound, creq, cack, testing, jstart, bfl, sfl;
  logic [7:0]  adr = 8'h00, run = 8'h00, cerr = 8'h00, derr = 8'h00, run_en, req, ca;
  logic [31:0] wdat = 32'h0, pval = 32'h0, rd, wb_dat;
  logic [15:0] pnum = 16'h0, jbase, jog_seen = 16'h0, ct;
  logic [3:0]  cb, sw = 4'h0;
  logic [2:0]  pport, jd;
  logic [1:0]  link = 2'b00, act = 2'b00;
  hds_pkg::hds_port_lamp_t [1:0] plamp;
  hds_pkg::hds_rg_t rsl;
  wire  [7:0]  lv = {plamp, bfl, sfl, rsl};
  int          n_mismatch = 0, n_tests = 0;
  logic [3:0]  t_sw [5] = '{4'h3, 4'h2, 4'h1, 4'h1, 4'h9};
  logic [7:0]  t_ce [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0]  t_de [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0]  t_ex [5] = '{8'h81, 8'h80, 8'h82, 8'h83, 8'h80};

  always #50 clk_i = ~clk_i;
  // last jog base given
  always @(posedge clk_i) if (jstart === 1'b1) jog_seen <= jbase;

  hds_supervisor #(.FLICKER_HALF(4), .ALT_HALF(8), .FLASH_HALF(FH), .IDENT_CYC(200)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(ack),
    .irq_o(irq), .link_up_i(link), .activity_i(act), .net_connected_i(conn),
    .cyclic_exchange_i(exch), .identify_req_i(ident), .watchdog_timeout_i(wdt),
    .system_fault_i(wdt), .diag_pending_i(wdt), .param_wr_i(pwr), .param_num_i(pnum),
    .param_val_i(pval), .run_cmd_i(run), .run_en_o(run_en), .drive_select_switch_i(sw),
    .backward_jog_key_i(bkey), .forward_jog_key_i(fkey), .jog_start_o(jstart),
    .jog_drive_o(jd), .jog_param_base_o(jbase), .comm_err_i(cerr), .drive_err_i(derr),
    .nv_required_i(8'h01), .required_o(req), .probe_req_o(preq), .probe_port_o(pport),
    .probe_done_i(pdone), .probe_found_i(pfound), .cfg_req_o(creq), .cfg_baud_o(cb),
    .cfg_timeout_o(ct), .cfg_addr_o(ca), .cfg_ack_i(cack), .testing_o(testing),
    .port_lamp_o(plamp), .bus_fault_lamp_o(bfl), .status_fault_lamp_o(sfl), .rs485_lamp_o(rsl)
  );
  hds_drive_model #(.PRESENT(8'h05)) drv_u (
    .clk_i(clk_i), .rst_i(rst_i), .probe_req_i(preq), .probe_port_i(pport), .cfg_req_i(creq),
    .probe_done_o(pdone), .probe_found_o(pfound), .cfg_ack_o(cack)
  );

  task automatic finish_test;
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; held until ack is seen at a rising edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
    rd = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic par(input logic [15:0] n, input logic [31:0] v);
    pwr <= 1'b1;
    pnum <= n;
    pval <= v;
    @(posedge clk_i);
    pwr <= 1'b0;
    @(posedge clk_i);
  endtask : par
  // or/and over a flash period tells steady from blinking
  task automatic lamps(input logic [7:0] any_e, input logic [7:0] all_e);
    logic [7:0] a, b;
    a = 8'h00;
    b = 8'hff;
    repeat (4) @(posedge clk_i);
    repeat (2 * FH + 4) begin
      @(posedge clk_i);
      a = a | lv;
      b = b & lv;
    end
    chk({24'h0, a}, {24'h0, any_e});
    chk({24'h0, b}, {24'h0, all_e});
  endtask : lamps
  task automatic wait_test;
    int k;
    k = 0;
    while (testing !== 1'b0 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    if (testing !== 1'b0) begin
      n_mismatch++;
      finish_test();
    end
  endtask : wait_test

  initial begin
    repeat (8) @(posedge clk_i);
    chk({31'h0, bfl}, 32'h1);
    chk({24'h0, req}, 32'h0);
    rst_i <= 1'b0;
    wait_test();
    chk({24'h0, req}, 32'h1);
    wb(8'h04, 1'b0, 32'h0);
    chk(rd & 32'h0000_ff01, 32'h0000_0500);
    wb(8'h18, 1'b1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wb(8'h14, 1'b1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wb(8'h20, 1'b0, 32'h0);
    chk(rd, 32'h0);
    lamps(8'h09, 8'h08);
    derr <= 8'h04;
    lamps(8'h0b, 8'h08);
    derr <= 8'h01;
    lamps(8'h0b, 8'h0b);
    derr <= 8'h00;
    cerr <= 8'h01;
    lamps(8'h0a, 8'h0a);
    cerr <= 8'h00;
    par(16'h015f, 32'h1);
    chk({24'h0, req}, 32'h5);
    conn <= 1'b1;
    link <= 2'b01;
    act <= 2'b01;
    lamps(8'h39, 8'h21);
    exch <= 1'b1;
    link <= 2'b10;
    act <= 2'b00;
    lamps(8'h81, 8'h81);
    for (int i = 0; i < 5; i++) begin
      sw <= t_sw[i];
      cerr <= t_ce[i];
      derr <= t_de[i];
      lamps(t_ex[i], t_ex[i]);
    end
    cerr <= 8'h00;
    derr <= 8'h00;
    run <= 8'hff;
    sw <= 4'h3;
    repeat (3) @(posedge clk_i);
    chk({24'h0, run_en}, 32'h0);
    sw <= 4'h0;
    repeat (3) @(posedge clk_i);
    chk({24'h0, run_en}, 32'h5);
    run <= 8'h00;
    sw <= 4'h3;
    bkey <= 1'b1;
    repeat (3) @(posedge clk_i);
    bkey <= 1'b0;
    chk({16'h0, jog_seen}, 32'h00a3);
    fkey <= 1'b1;
    repeat (3) @(posedge clk_i);
    fkey <= 1'b0;
    chk({16'h0, jog_seen}, 32'h00a0);
    chk({29'h0, jd}, 32'h2);
    sw <= 4'h0;
    ident <= 1'b1;
    @(posedge clk_i);
    ident <= 1'b0;
    lamps(8'h85, 8'h81);
    repeat (200) @(posedge clk_i);
    lamps(8'h81, 8'h81);
    wdt <= 1'b1;
    lamps(8'h85, 8'h85);
    wdt <= 1'b0;
    par(16'h001d, 32'hffff_fffc);
    chk({31'h0, testing}, 32'h1);
    wait_test();
    chk({24'h0, req}, 32'h1);
    wb(8'h08, 1'b1, 32'ha5);
    wb(8'h08, 1'b0, 32'h0);
    chk(rd & 32'hff, 32'ha5);
    finish_test();
  end
endmodule : testbench
